// ---- logic/acrt_pkg.sv ----
// package of offsets, field layouts and reset values for the result and trim registers
`default_nettype none

package acrt_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] ACRT_TEMP_CHAN1_RESULT_HIGH = 8'h2C;
  localparam logic [7:0] ACRT_TEMP_CHAN1_RESULT_LOW  = 8'h2D;
  localparam logic [7:0] ACRT_TEMP_CHAN2_RESULT_HIGH = 8'h2E;
  localparam logic [7:0] ACRT_TEMP_CHAN2_RESULT_LOW  = 8'h2F;
  localparam logic [7:0] ACRT_TEMP_CHAN3_RESULT_HIGH = 8'h30;
  localparam logic [7:0] ACRT_TEMP_CHAN3_RESULT_LOW  = 8'h31;
  localparam logic [7:0] ACRT_CHARGE_COUNT_HIGH      = 8'h32;
  localparam logic [7:0] ACRT_CHARGE_COUNT_LOW       = 8'h33;
  localparam logic [7:0] ACRT_GAIN_TRIM_UPPER        = 8'h50;
  localparam logic [7:0] ACRT_OFFSET_TRIM            = 8'h51;
  localparam logic [7:0] ACRT_GAIN_TRIM_LOWER        = 8'h59;

  // ****************************************************************
  // field layouts and widths
  // ****************************************************************
  localparam int         ACRT_TEMP_W      = 14;
  localparam int         ACRT_TEMP_HI_W   = 6;
  localparam int         ACRT_CC_W        = 16;
  localparam int         ACRT_GAIN_W      = 5;
  localparam int         ACRT_OFFSET_W    = 8;
  localparam int         ACRT_GAIN_UP_LSB = 2;
  localparam int         ACRT_GAIN_LO_LSB = 5;
  localparam logic [7:0] ACRT_READ_ZERO   = 8'h00;
  localparam logic [7:0] ACRT_RESULT_RST  = 8'h00;

  // ****************************************************************
  // gain formula constants for the host side, microvolts per step
  // ****************************************************************
  localparam int         ACRT_GAIN_BASE_UV = 365;
  localparam int         ACRT_GAIN_STEP_UV = 1;

endpackage : acrt_pkg

`default_nettype wire

// ---- logic/acrt_result_hold.sv ----
// one result holding register that defers updates while a read transaction runs
`default_nettype none

module acrt_result_hold
  import acrt_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // sample side
  input  wire logic         sample_valid,
  input  wire logic [W-1:0] sample_data,
  // transaction freeze
  input  wire logic         freeze,
  // held value
  output logic      [W-1:0] held
);

  logic [W-1:0] held_reg;
  logic [W-1:0] pend_reg;
  logic         pend_valid_reg;

  assign held = held_reg;

  // a sample arriving during a transaction waits so both bytes stay one sample
  always_ff @(posedge mclk) begin
    if (reset) begin
      held_reg       <= W'(ACRT_RESULT_RST);
      pend_reg       <= W'(ACRT_RESULT_RST);
      pend_valid_reg <= 1'b0;
    end else if (freeze) begin
      if (sample_valid) begin
        pend_reg       <= sample_data;
        pend_valid_reg <= 1'b1;
      end
    end else begin
      // newest sample wins over an older pending one
      if (sample_valid) begin
        held_reg <= sample_data;
      end else if (pend_valid_reg) begin
        held_reg <= pend_reg;
      end
      pend_valid_reg <= 1'b0;
    end
  end

endmodule : acrt_result_hold

`default_nettype wire

// ---- logic/acrt_regs.sv ----
// read-only result and factory trim register group behind the serial register port
`default_nettype none

module acrt_regs
  import acrt_pkg::*;
(
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     reset,
  // register port from the serial front end
  input  wire logic                     reg_txn_active,
  input  wire logic [7:0]               reg_addr,
  input  wire logic                     reg_rd,
  input  wire logic                     reg_wr,
  input  wire logic [7:0]               reg_wdata,
  output logic      [7:0]               reg_rdata,
  output logic                          reg_hit,
  // temperature conversions
  input  wire logic                     temp_chan1_src_die,
  input  wire logic                     temp_chan1_valid,
  input  wire logic [ACRT_TEMP_W-1:0]   temp_chan1_data,
  input  wire logic                     internal_die_temperature_valid,
  input  wire logic [ACRT_TEMP_W-1:0]   internal_die_temperature_data,
  input  wire logic                     temp_chan2_valid,
  input  wire logic [ACRT_TEMP_W-1:0]   temp_chan2_data,
  input  wire logic                     temp_chan3_valid,
  input  wire logic [ACRT_TEMP_W-1:0]   temp_chan3_data,
  // coulomb counter
  input  wire logic                     charge_count_valid,
  input  wire logic [ACRT_CC_W-1:0]     charge_count_data,
  // factory trim fuses
  input  wire logic [ACRT_GAIN_W-1:0]   gain_trim_code_fuse,
  input  wire logic [ACRT_OFFSET_W-1:0] offset_trim_code_fuse
);

  // ****************************************************************
  // result holding
  // ****************************************************************
  logic                     ch1_valid;
  logic [ACRT_TEMP_W-1:0]   ch1_data;
  logic [ACRT_TEMP_W-1:0]   ch1_held;
  logic [ACRT_TEMP_W-1:0]   ch2_held;
  logic [ACRT_TEMP_W-1:0]   ch3_held;
  logic [ACRT_CC_W-1:0]     cc_held;

  // first channel follows whichever source is selected
  assign ch1_valid = temp_chan1_src_die ? internal_die_temperature_valid : temp_chan1_valid;
  assign ch1_data  = temp_chan1_src_die ? internal_die_temperature_data  : temp_chan1_data;

  acrt_result_hold #(.W(ACRT_TEMP_W)) u_ch1 (
    .mclk         (mclk),
    .reset        (reset),
    .sample_valid (ch1_valid),
    .sample_data  (ch1_data),
    .freeze       (reg_txn_active),
    .held         (ch1_held)
  );

  acrt_result_hold #(.W(ACRT_TEMP_W)) u_ch2 (
    .mclk         (mclk),
    .reset        (reset),
    .sample_valid (temp_chan2_valid),
    .sample_data  (temp_chan2_data),
    .freeze       (reg_txn_active),
    .held         (ch2_held)
  );

  acrt_result_hold #(.W(ACRT_TEMP_W)) u_ch3 (
    .mclk         (mclk),
    .reset        (reset),
    .sample_valid (temp_chan3_valid),
    .sample_data  (temp_chan3_data),
    .freeze       (reg_txn_active),
    .held         (ch3_held)
  );

  acrt_result_hold #(.W(ACRT_CC_W)) u_cc (
    .mclk         (mclk),
    .reset        (reset),
    .sample_valid (charge_count_valid),
    .sample_data  (charge_count_data),
    .freeze       (reg_txn_active),
    .held         (cc_held)
  );

  // ****************************************************************
  // trim capture
  // ****************************************************************
  logic                     trim_loaded_reg;
  logic [ACRT_GAIN_W-1:0]   gain_trim_reg;
  logic [ACRT_OFFSET_W-1:0] offset_trim_reg;

  // fuses are caught once after reset release; no write path exists
  always_ff @(posedge mclk) begin
    if (reset) begin
      trim_loaded_reg <= 1'b0;
      gain_trim_reg   <= '0;
      offset_trim_reg <= '0;
    end else if (!trim_loaded_reg) begin
      trim_loaded_reg <= 1'b1;
      gain_trim_reg   <= gain_trim_code_fuse;
      offset_trim_reg <= offset_trim_code_fuse;
    end
  end

  // ****************************************************************
  // read decode
  // ****************************************************************
  logic [7:0] rd_mux;
  logic       rd_hit;

  // unused bits read as zero and unmapped addresses read zero
  always_comb begin
    rd_mux = ACRT_READ_ZERO;
    rd_hit = 1'b1;
    case (reg_addr)
      ACRT_TEMP_CHAN1_RESULT_HIGH: rd_mux = 8'(ch1_held[ACRT_TEMP_W-1:8]);
      ACRT_TEMP_CHAN1_RESULT_LOW:  rd_mux = ch1_held[7:0];
      ACRT_TEMP_CHAN2_RESULT_HIGH: rd_mux = 8'(ch2_held[ACRT_TEMP_W-1:8]);
      ACRT_TEMP_CHAN2_RESULT_LOW:  rd_mux = ch2_held[7:0];
      ACRT_TEMP_CHAN3_RESULT_HIGH: rd_mux = 8'(ch3_held[ACRT_TEMP_W-1:8]);
      ACRT_TEMP_CHAN3_RESULT_LOW:  rd_mux = ch3_held[7:0];
      ACRT_CHARGE_COUNT_HIGH:      rd_mux = cc_held[ACRT_CC_W-1:8];
      ACRT_CHARGE_COUNT_LOW:       rd_mux = cc_held[7:0];
      ACRT_GAIN_TRIM_UPPER:
        rd_mux = 8'({gain_trim_reg[4:3], 2'b00});
      ACRT_OFFSET_TRIM:            rd_mux = offset_trim_reg;
      ACRT_GAIN_TRIM_LOWER:
        rd_mux = {gain_trim_reg[2:0], 5'b00000};
      default: begin
        rd_mux = ACRT_READ_ZERO;
        rd_hit = 1'b0;
      end
    endcase
  end

  // read data is registered; writes are accepted and dropped
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= ACRT_READ_ZERO;
      reg_hit   <= 1'b0;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
      reg_hit   <= rd_hit;
    end
  end

  // write strobe and data are deliberately ignored by this group
  logic unused_wr;
  assign unused_wr = reg_wr ^ (^reg_wdata);

endmodule : acrt_regs

`default_nettype wire

// ---- verification/acrt_chk_sva.sv ----
// read answer checks for the result and trim register group
`default_nettype none
module acrt_chk
  import acrt_pkg::*;
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // register port
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_hit,
  // factory fuses, changed by the bench only while reset is held
  input wire logic [4:0] gain_trim_code_fuse,
  input wire logic [7:0] offset_trim_code_fuse
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // every answer lands one cycle after the read strobe
  unmap_read_a: assert property (reg_rd && !(reg_addr inside {[8'h2C:8'h33], 8'h50, 8'h51,
    8'h59}) |=> reg_rdata == 8'h00 && !reg_hit) else $error("unmapped read wrong");
  map_hit_a: assert property (reg_rd && reg_addr inside {[8'h2C:8'h33], 8'h50, 8'h51, 8'h59}
    |=> reg_hit) else $error("mapped read missed");
  temp_high_a: assert property (reg_rd && reg_addr inside {8'h2C, 8'h2E, 8'h30}
    |=> reg_rdata[7:6] == 2'h0) else $error("temp high spare bits set");
  gain_up_a: assert property (reg_rd && reg_addr == 8'h50 |=> reg_rdata ==
    {4'h0, gain_trim_code_fuse[4:3], 2'h0}) else $error("gain upper wrong");
  gain_low_a: assert property (reg_rd && reg_addr == 8'h59 |=> reg_rdata ==
    {gain_trim_code_fuse[2:0], 5'h00}) else $error("gain lower wrong");
  offset_val_a: assert property (reg_rd && reg_addr == 8'h51
    |=> reg_rdata == offset_trim_code_fuse) else $error("offset wrong");
  // without a read the answer must not move, writes included
  answer_hold_a: assert property (!reg_rd |=> $stable(reg_rdata) && $stable(reg_hit))
    else $error("answer moved");
  reset_clear_a: assert property ($fell(reset) |-> reg_rdata == 8'h00 && !reg_hit)
    else $error("reset answer wrong");
endmodule : acrt_chk
`default_nettype wire

// ---- verification/acrt_host.sv ----
// host model issuing register reads and writes
`default_nettype none
module acrt_host
  import acrt_pkg::*;
(
  // clock and answer
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  // requests
  output var logic        reg_txn_active,
  output var logic [7:0]  reg_addr,
  output var logic        reg_rd,
  output var logic        reg_wr,
  output var logic [7:0]  reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus at time zero
  initial begin
    reg_txn_active = 1'b0;
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // strobe stays up so reads may run back to back
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1;
  endtask : wr
  // released address shows its inverse so stale values cannot pass
  task automatic stop();
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = ~reg_addr;
    @(posedge mclk);
    #1;
  endtask : stop
  function automatic int gain_uv(input logic [4:0] c);
    return ACRT_GAIN_BASE_UV + c * ACRT_GAIN_STEP_UV;
  endfunction : gain_uv
endmodule : acrt_host
`default_nettype wire

// ---- verification/tb_top.sv ----
// testbench for the result and trim register group
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import acrt_pkg::*;
  logic        mclk = 1'b0, reset = 1'b1, src = 1'b0, txn, rd, wr, hit;
  logic [4:0]  v = 5'h00;
  logic [13:0] d [5] = '{default: 14'h0};
  logic [15:0] ccd = 16'h0000;
  logic [4:0]  gfuse = 5'h1B;
  logic [7:0]  ofuse = 8'h80;
  logic [7:0]  addr, wdata, rdata, q, q2;
  int          n_fail = 0, tests_run = 0;
  acrt_host host_u (.mclk, .reg_rdata(rdata), .reg_txn_active(txn), .reg_addr(addr),
    .reg_rd(rd), .reg_wr(wr), .reg_wdata(wdata));
  acrt_regs dut_u (.mclk, .reset, .reg_txn_active(txn), .reg_addr(addr), .reg_rd(rd),
    .reg_wr(wr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_hit(hit),
    .temp_chan1_src_die(src), .temp_chan1_valid(v[0]), .temp_chan1_data(d[0]),
    .internal_die_temperature_valid(v[1]), .internal_die_temperature_data(d[1]),
    .temp_chan2_valid(v[2]), .temp_chan2_data(d[2]), .temp_chan3_valid(v[3]),
    .temp_chan3_data(d[3]), .charge_count_valid(v[4]), .charge_count_data(ccd),
    .gain_trim_code_fuse(gfuse), .offset_trim_code_fuse(ofuse));
  initial forever #4 mclk = ~mclk;
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic chk_uv(input string n, input int e, input int g);
    tests_run++;
    if (g != e) begin
      n_fail++;
      $display("unexpected %s exp %0d got %0d", n, e, g);
    end
  endtask : chk_uv
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, q);
    host_u.stop();
    chk(n, e, q);
  endtask : rc
  task automatic pulse(input int i);
    v[i] = 1'b1;
    tick();
    v[i] = 1'b0;
  endtask : pulse
  task automatic t_temps();
    rc("charge_count_high", 8'h32, 8'h00);
    rc("charge_count_low", 8'h33, 8'h00);
    d[2] = 14'h2ABC;
    pulse(2);
    rc("t2_hi", 8'h2E, 8'h2A);
    rc("t2_lo", 8'h2F, 8'hBC);
    d[3] = 14'h3F01;
    pulse(3);
    rc("t3_hi", 8'h30, 8'h3F);
    rc("t3_lo", 8'h31, 8'h01);
    d[0] = 14'h1234;
    pulse(0);
    rc("t1_lo", 8'h2D, 8'h34);
    src = 1'b1;
    d[1] = 14'h0F77;
    pulse(1);
    rc("die_hi", 8'h2C, 8'h0F);
    $display("temps done");
  endtask : t_temps
  task automatic t_atomic();
    ccd = 16'hA55A;
    pulse(4);
    host_u.reg_txn_active = 1'b1;
    // new sample lands on the high-byte read edge; without the freeze the pair tears
    ccd = 16'h1234;
    v[4] = 1'b1;
    host_u.rd(8'h32, q);
    v[4] = 1'b0;
    host_u.rd(8'h33, q2);
    host_u.stop();
    chk("pair_hi", 8'hA5, q);
    chk("pair_lo", 8'h5A, q2);
    host_u.reg_txn_active = 1'b0;
    tick();
    rc("late_lo", 8'h33, 8'h34);
    rc("late_hi", 8'h32, 8'h12);
    $display("atomic done");
  endtask : t_atomic
  task automatic t_trim();
    rc("gain_up", 8'h50, 8'h0C);
    rc("gain_lo", 8'h59, 8'h60);
    host_u.rd(8'h50, q);
    host_u.rd(8'h59, q2);
    host_u.stop();
    chk_uv("gain_uv", 392, host_u.gain_uv({q[3:2], q2[7:5]}));
    host_u.wr(8'h51, 8'h7F);
    host_u.stop();
    rc("offset", 8'h51, 8'h80);
    host_u.wr(8'h50, 8'hFF);
    host_u.stop();
    rc("gain_wr", 8'h50, 8'h0C);
    chk("hit_map", 8'h01, {7'h0, hit});
    rc("unmapped", 8'h34, 8'h00);
    chk("hit", 8'h00, {7'h0, hit});
    $display("trim done");
  endtask : t_trim
  // mid-run reset with new fuse levels: results clear and trims are caught again
  task automatic t_refuse();
    reset = 1'b1;
    gfuse = 5'h04;
    ofuse = 8'h7F;
    repeat (2) tick();
    reset = 1'b0;
    repeat (2) tick();
    rc("rst_cc", 8'h32, 8'h00);
    rc("gain_up2", 8'h50, 8'h00);
    rc("gain_lo2", 8'h59, 8'h80);
    rc("offset2", 8'h51, 8'h7F);
    $display("refuse done");
  endtask : t_refuse
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // reset for four cycles, trims are caught on the first edge after release
  initial begin
    repeat (4) @(posedge mclk);
    #1;
    reset = 1'b0;
    repeat (2) tick();
    t_temps();
    t_atomic();
    t_trim();
    t_refuse();
    wrap_up();
  end
endmodule : tb_top
bind acrt_regs acrt_chk chk_u (.mclk, .reset, .reg_rd, .reg_addr, .reg_rdata, .reg_hit,
  .gain_trim_code_fuse, .offset_trim_code_fuse);
`default_nettype wire
